/* File: verilog/acp_config_port.sv */
// Serial configuration port with register set and power-down control
`timescale 1ns/100ps

module acp_config_port (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                clk_en,
    input  wire logic                reset_pin,
    input  wire logic                serial_clk,
    input  wire logic                serial_select_n,
    input  wire logic                serial_in_line,
    output logic                     serial_out_line,
    output logic                     serial_out_oe_n,
    input  wire logic                powerdown_select_first,
    input  wire logic                powerdown_select_second,
    input  wire logic                global_powerdown_pin,
    input  wire logic                standby_pin,
    output acp_pkg::acp_power_t      power_state,
    output acp_pkg::acp_div_t        sample_clock_divide,
    output logic [2:0]               reference_input_skew,
    output logic [9:0]               reference_skew_ps
);

    acp_pkg::acp_state_t st_ff;
    acp_pkg::acp_state_t nxt_st;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic                             sclk_rise;
    logic                             sclk_fall;
    logic                             selected;
    logic [acp_pkg::FRAME_BITS-1:0]   word;
    logic [5:0]                       addr;
    logic [7:0]                       rd_sel;

    always_comb begin
        nxt_st    = st_ff;
        sclk_rise = st_ff.sclk_sync[1] & ~st_ff.sclk_sync[2];
        sclk_fall = ~st_ff.sclk_sync[1] & st_ff.sclk_sync[2];
        selected  = ~st_ff.sen_sync[1];
        word      = {st_ff.shift, st_ff.din_sync[1]};
        addr      = word[acp_pkg::ADDR_MSB-acp_pkg::ADDR_LSB:0];
        nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], serial_clk};
        nxt_st.sen_sync  = {st_ff.sen_sync[0], serial_select_n};
        nxt_st.din_sync  = {st_ff.din_sync[0], serial_in_line};
        nxt_st.pins_s1   = {powerdown_select_first, powerdown_select_second,
                            global_powerdown_pin, standby_pin};
        nxt_st.pins_s2   = st_ff.pins_s1;
        nxt_st.rst_sync  = {st_ff.rst_sync[0], reset_pin};
        nxt_st.power[acp_pkg::SWRST_POS] = 1'b0;
        case (addr)
            acp_pkg::OFF_CLK_DIVIDE: rd_sel = {6'h00, st_ff.clk_div};
            acp_pkg::OFF_REF_DELAY:  rd_sel = {5'h00, st_ff.ref_delay};
            acp_pkg::OFF_POWER_CTRL: rd_sel = st_ff.power;
            default:                 rd_sel = 8'h00;
        endcase
        if (!selected) begin
            nxt_st.bit_cnt    = '0;
            nxt_st.read_frame = 1'b0;
            nxt_st.sdo_oe_n   = 1'b1;
        end else if (sclk_rise) begin
            nxt_st.shift   = word[acp_pkg::FRAME_BITS-2:0];
            nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
            nxt_st.rd_data = {st_ff.rd_data[6:0], 1'b0};
            if (st_ff.bit_cnt == acp_pkg::CNT_W'(acp_pkg::ADDR_LSB - 1)) begin
                nxt_st.read_frame = st_ff.shift[acp_pkg::ADDR_LSB-2];
                nxt_st.rd_data    = rd_sel;
            end
            if (st_ff.bit_cnt == acp_pkg::CNT_W'(acp_pkg::FRAME_BITS - 1)) begin
                nxt_st.read_frame = 1'b0;
                if (!word[acp_pkg::RW_POS]) begin
                    case (word[acp_pkg::ADDR_MSB:acp_pkg::ADDR_LSB])
                        acp_pkg::OFF_CLK_DIVIDE: nxt_st.clk_div = word[1:0];
                        acp_pkg::OFF_REF_DELAY:  nxt_st.ref_delay = word[2:0];
                        acp_pkg::OFF_POWER_CTRL: nxt_st.power = word[7:0] & (acp_pkg::POWER_WMASK | 8'h01);
                        default: ;
                    endcase
                end
            end
        end else if (sclk_fall) begin
            nxt_st.sdo      = st_ff.rd_data[7];
            nxt_st.sdo_oe_n = ~st_ff.read_frame;
        end
        if (st_ff.power[acp_pkg::SWRST_POS] || st_ff.rst_sync[1]) begin
            nxt_st.clk_div   = acp_pkg::RST_CLK_DIV;
            nxt_st.ref_delay = acp_pkg::RST_REF_DELAY;
            nxt_st.power     = acp_pkg::RST_POWER;
        end
        // Pin or register, whichever asks, powers down a channel or standby; global power-down comes from the pins only
        nxt_st.pwr.global_off = st_ff.pins_s2[1] | (st_ff.pins_s2[3] & st_ff.pins_s2[2]);
        nxt_st.pwr.chan_a_off = st_ff.power[acp_pkg::PD_CHA_POS]
                              | (st_ff.pins_s2[3] & ~st_ff.pins_s2[2]);
        nxt_st.pwr.chan_b_off = st_ff.power[acp_pkg::PD_CHB_POS]
                              | (~st_ff.pins_s2[3] & st_ff.pins_s2[2]);
        nxt_st.pwr.standby    = st_ff.power[acp_pkg::STANDBY_PIN_POS] | st_ff.pins_s2[0];
        case (st_ff.clk_div)
            acp_pkg::DIV_CODE_2: nxt_st.div_mode = acp_pkg::ACP_DIV2;
            acp_pkg::DIV_CODE_4: nxt_st.div_mode = acp_pkg::ACP_DIV4;
            default:             nxt_st.div_mode = acp_pkg::ACP_DIV1;
        endcase
        nxt_st.skew_ps = 10'(st_ff.ref_delay * acp_pkg::SKEW_STEP_PS);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff          <= '0;
            st_ff.sen_sync <= 2'h3;
            st_ff.sdo_oe_n <= 1'b1;
            st_ff.div_mode <= acp_pkg::ACP_DIV1;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign serial_out_line      = st_ff.sdo;
    assign serial_out_oe_n      = st_ff.sdo_oe_n;
    assign power_state          = st_ff.pwr;
    assign sample_clock_divide  = st_ff.div_mode;
    assign reference_input_skew = st_ff.ref_delay;
    assign reference_skew_ps    = st_ff.skew_ps;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    counter_clear_a: assert property (clk_en && st_ff.sen_sync[1] |=> st_ff.bit_cnt == '0)
        else $error("bit counter not cleared on deselect");
    idle_no_shift_a: assert property (clk_en && st_ff.sen_sync[1] |=> $stable(st_ff.shift))
        else $error("shift moved while deselected");
    rise_count_a: assert property (clk_en && selected && sclk_rise
            |=> st_ff.bit_cnt == $past(st_ff.bit_cnt) + 1'b1)
        else $error("rising edge not counted");
    swrst_clear_a: assert property (clk_en && st_ff.power[0] |=> st_ff.power == '0 && st_ff.clk_div == '0)
        else $error("software reset did not clear registers");
    write_hiz_a: assert property (clk_en && !st_ff.read_frame && selected && sclk_fall |=> st_ff.sdo_oe_n)
        else $error("output driven in write frame");
    sdo_fall_a: assert property (clk_en && !sclk_fall |=> $stable(st_ff.sdo))
        else $error("serial output changed off falling edge");
    pin_global_a: assert property (clk_en && st_ff.pins_s2[1] |=> st_ff.pwr.global_off)
        else $error("global pin ignored");
    standby_pin_reg_a: assert property (clk_en && st_ff.power[5] |=> st_ff.pwr.standby)
        else $error("standby bit ignored");
    div_map_a: assert property (clk_en && st_ff.clk_div == 2'h2 |=> st_ff.div_mode == acp_pkg::ACP_DIV1)
        else $error("divider code 10 not divide by 1");

    // ----------------------------------------
    // Frame, readback and reset-pin checks
    // ----------------------------------------
    rise_shift_a: assert property (clk_en && selected && sclk_rise
            |=> st_ff.shift[0] == $past(st_ff.din_sync[1]))
        else $error("serial input not sampled on rising edge");
    frame_load_a: assert property (clk_en && selected && sclk_rise && st_ff.bit_cnt == 4'hF
            && word[15:8] == {2'h0, acp_pkg::OFF_REF_DELAY}
            && !st_ff.rst_sync[1] && !st_ff.power[acp_pkg::SWRST_POS]
            |=> st_ff.ref_delay == $past(word[2:0]))
        else $error("complete word not loaded");
    read_drive_a: assert property (clk_en && st_ff.read_frame && selected && sclk_fall
            |=> !st_ff.sdo_oe_n)
        else $error("readback not driven in data phase");
    deselect_hiz_a: assert property (clk_en && !selected |=> st_ff.sdo_oe_n)
        else $error("output driven while deselected");
    pin_reset_a: assert property (clk_en && st_ff.rst_sync[1]
            |=> st_ff.power == '0 && st_ff.ref_delay == '0 && st_ff.clk_div == '0)
        else $error("reset pin did not clear registers");

    // ----------------------------------------
    // Power-down and mapping checks
    // ----------------------------------------
    chan_a_pin_a: assert property (clk_en && st_ff.pins_s2[3:1] == 3'h4
            |=> st_ff.pwr.chan_a_off && !st_ff.pwr.global_off)
        else $error("first select pin did not power down channel A");
    chan_b_pin_a: assert property (clk_en && st_ff.pins_s2[3:1] == 3'h2
            |=> st_ff.pwr.chan_b_off && !st_ff.pwr.global_off)
        else $error("second select pin did not power down channel B");
    both_pins_a: assert property (clk_en && st_ff.pins_s2[3:2] == 2'h3 |=> st_ff.pwr.global_off)
        else $error("both select pins did not give global power-down");
    standby_pin_pin_a: assert property (clk_en && st_ff.pins_s2[0] |=> st_ff.pwr.standby)
        else $error("standby pin ignored");
    chan_a_reg_a: assert property (clk_en && st_ff.power[acp_pkg::PD_CHA_POS] |=> st_ff.pwr.chan_a_off)
        else $error("channel A bit ignored");
    chan_b_reg_a: assert property (clk_en && st_ff.power[acp_pkg::PD_CHB_POS] |=> st_ff.pwr.chan_b_off)
        else $error("channel B bit ignored");
    idle_power_a: assert property (clk_en && st_ff.pins_s2 == '0 && st_ff.power[7:5] == '0
            |=> st_ff.pwr == '0)
        else $error("power-down without request");
    div2_map_a: assert property (clk_en && st_ff.clk_div == acp_pkg::DIV_CODE_2
            |=> st_ff.div_mode == acp_pkg::ACP_DIV2)
        else $error("divider code 01 not divide by 2");
    div4_map_a: assert property (clk_en && st_ff.clk_div == acp_pkg::DIV_CODE_4
            |=> st_ff.div_mode == acp_pkg::ACP_DIV4)
        else $error("divider code 11 not divide by 4");
    skew_max_a: assert property (clk_en && st_ff.ref_delay == 3'h7 |=> st_ff.skew_ps == 10'h1A4)
        else $error("largest delay code not 420 ps");
    skew_zero_a: assert property (clk_en && st_ff.ref_delay == 3'h0 |=> st_ff.skew_ps == 10'h000)
        else $error("zero delay code not 0 ps");

    frame_cov: cover property (clk_en && selected && sclk_rise && st_ff.bit_cnt == 4'hF);
    read_cov:  cover property (clk_en && !st_ff.sdo_oe_n);
    reset_cov: cover property (clk_en && st_ff.power[0]);
    pin_reset_cov: cover property (clk_en && st_ff.rst_sync[1]);
    both_pins_cov: cover property (clk_en && st_ff.pins_s2[3:2] == 2'h3);

endmodule // acp_config_port

/* File: verilog/acp_pkg.sv */
// Package: constants and carriers for the serial configuration port
package acp_pkg;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int unsigned FRAME_BITS   = 16;
    localparam int unsigned CNT_W        = 4;
    localparam int unsigned RW_POS       = 15;
    localparam int unsigned A6_POS       = 14;
    localparam int unsigned ADDR_MSB     = 13;
    localparam int unsigned ADDR_LSB     = 8;
    localparam int unsigned DATA_BITS    = 8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [5:0] OFF_CLK_DIVIDE = 6'h06;
    localparam logic [5:0] OFF_REF_DELAY  = 6'h07;
    localparam logic [5:0] OFF_POWER_CTRL = 6'h08;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int unsigned PD_CHA_POS   = 7;
    localparam int unsigned PD_CHB_POS   = 6;
    localparam int unsigned STANDBY_PIN_POS     = 5;
    localparam int unsigned SWRST_POS    = 0;
    localparam logic [1:0] RST_CLK_DIV   = 2'h0;
    localparam logic [2:0] RST_REF_DELAY = 3'h0;
    localparam logic [7:0] RST_POWER     = 8'h00;
    localparam logic [7:0] POWER_WMASK   = 8'hF8;

    // ----------------------------------------
    // Divider codes and skew step
    // ----------------------------------------
    localparam logic [1:0] DIV_CODE_2    = 2'h1;
    localparam logic [1:0] DIV_CODE_4    = 2'h3;
    localparam int unsigned SKEW_STEP_PS = 60;

    typedef enum logic [1:0] {
        ACP_DIV1,
        ACP_DIV2,
        ACP_DIV4
    } acp_div_t;

    typedef struct packed {
        logic chan_a_off;
        logic chan_b_off;
        logic standby;
        logic global_off;
    } acp_power_t;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [1:0] sen_sync;
        logic [1:0] din_sync;
        logic [1:0] rst_sync;
        logic [CNT_W-1:0] bit_cnt;
        logic [FRAME_BITS-2:0] shift;
        logic       read_frame;
        logic [7:0] rd_data;
        logic       sdo;
        logic       sdo_oe_n;
        logic [1:0] clk_div;
        logic [2:0] ref_delay;
        logic [7:0] power;
        logic [3:0] pins_s1;
        logic [3:0] pins_s2;
        acp_power_t pwr;
        acp_div_t   div_mode;
        logic [9:0] skew_ps;
    } acp_state_t;

endpackage : acp_pkg

/* File: sim/acp_host_model.sv */
// Host controller model driving the serial configuration pins
`timescale 1ns/100ps
module acp_host_model (
    input  wire logic clk,
    output logic      serial_clk,
    output logic      serial_select_n,
    output logic      serial_in_line,
    input  wire logic serial_out_line
);
    // Idle levels follow the pin pulls
    initial begin
        serial_clk      = 1'b0;
        serial_select_n = 1'b1;
        serial_in_line  = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Frame of n bits, MSB first
    task automatic xfer(input logic [31:0] w, input int n, input int half, output logic [7:0] rd);
        rd = 8'h00;
        serial_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in_line = w[i];
            step(half);
            serial_clk = 1'b1;
            rd = {rd[6:0], serial_out_line};
            step(half);
            serial_clk = 1'b0;
        end
        step(half);
        serial_select_n = 1'b1;
        serial_in_line  = 1'b0;
        step(12);
    endtask
endmodule // acp_host_model

/* File: sim/acp_config_port_test.sv */
// Self-checking testbench for the serial configuration port
`timescale 1ns/100ps
module acp_config_port_test;
    logic                clk, rstn, reset_pin, sclk, sel_n, sdi, sdo, sdo_oe_n, in_write;
    logic                cen, sdo_pin;
    logic [3:0]          pins;
    acp_pkg::acp_power_t pwr;
    acp_pkg::acp_div_t   div;
    logic [2:0]          skew;
    logic [9:0]          skew_ps;
    logic [7:0]          rd;
    int                  bad_count, samples_checked;
    acp_pkg::acp_div_t   div_exp [4] = '{acp_pkg::ACP_DIV1, acp_pkg::ACP_DIV2,
                                         acp_pkg::ACP_DIV1, acp_pkg::ACP_DIV4};
    logic [3:0]          pin_in [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [3:0]          pwr_exp [4] = '{4'h8, 4'h4, 4'h1, 4'h2};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    acp_config_port dut (
        .clk(clk), .rstn(rstn), .clk_en(cen), .reset_pin(reset_pin),
        .serial_clk(sclk), .serial_select_n(sel_n), .serial_in_line(sdi),
        .serial_out_line(sdo), .serial_out_oe_n(sdo_oe_n),
        .powerdown_select_first(pins[3]), .powerdown_select_second(pins[2]),
        .global_powerdown_pin(pins[1]), .standby_pin(pins[0]), .power_state(pwr),
        .sample_clock_divide(div), .reference_input_skew(skew), .reference_skew_ps(skew_ps)
    );

    acp_host_model host (
        .clk(clk), .serial_clk(sclk), .serial_select_n(sel_n),
        .serial_in_line(sdi), .serial_out_line(sdo_pin)
    );

    // Released readback line shows the inverse
    assign sdo_pin = sdo_oe_n ? ~sdo : sdo;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        in_write = 1'b1;
        host.xfer({16'h0000, 2'b00, a, d}, 16, 8, rd);
        in_write = 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        host.xfer({16'h0000, 2'b10, a, 8'h00}, 16, 8, rd);
        chk(16'(rd), 16'(exp));
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(negedge clk) if (in_write) chk(16'(sdo_oe_n), 16'h0001);

    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0; reset_pin = 1'b0; pins = 4'h0; in_write = 1'b0;
        cen = 1'b1;
        bad_count = 0; samples_checked = 0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        reset_pin = 1'b1;
        host.step(5);
        reset_pin = 1'b0;
        host.step(25);
        for (int k = 6; k < 9; k++) rdchk(6'(k), 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(acp_pkg::OFF_CLK_DIVIDE, 8'(c));
            chk(16'(div), 16'(div_exp[c]));
            rdchk(acp_pkg::OFF_CLK_DIVIDE, 8'(c));
        end
        for (int c = 0; c < 8; c++) begin
            wr(acp_pkg::OFF_REF_DELAY, 8'(c));
            chk(16'(skew), 16'(c));
            chk(16'(skew_ps), 16'(c * acp_pkg::SKEW_STEP_PS));
            rdchk(acp_pkg::OFF_REF_DELAY, 8'(c));
        end
        wr(acp_pkg::OFF_CLK_DIVIDE, 8'h01);
        host.xfer(32'h0000_0603 >> 1, 15, 20, rd);
        chk(16'(div), 16'(acp_pkg::ACP_DIV2));
        host.xfer({2'b00, 6'h06, 8'h03, 2'b00, 6'h07, 8'h05}, 32, 8, rd);
        chk({div, 11'h000, skew}, {acp_pkg::ACP_DIV4, 11'h000, 3'h5});
        for (int b = 0; b < 3; b++) begin
            wr(acp_pkg::OFF_POWER_CTRL, 8'h80 >> b);
            chk(16'(pwr), 16'(4'h8 >> b));
            rdchk(acp_pkg::OFF_POWER_CTRL, 8'h80 >> b);
        end
        wr(acp_pkg::OFF_POWER_CTRL, 8'h01);
        chk({div, 11'h000, skew}, 16'h0000);
        rdchk(acp_pkg::OFF_POWER_CTRL, 8'h00);
        cen = 1'b0;
        wr(acp_pkg::OFF_CLK_DIVIDE, 8'h03);
        cen = 1'b1;
        host.step(4);
        chk(16'(div), 16'(acp_pkg::ACP_DIV1));
        rdchk(acp_pkg::OFF_CLK_DIVIDE, 8'h00);
        for (int p = 0; p < 4; p++) begin
            pins = pin_in[p];
            host.step(8);
            chk(16'(pwr), 16'(pwr_exp[p]));
        end
        pins = 4'hC;
        host.step(8);
        chk(16'(pwr), 16'h0001);
        pins = 4'h0;
        wr(6'h0B, 8'h55);
        rdchk(6'h0B, 8'h00);
        wr(acp_pkg::OFF_REF_DELAY, 8'h07);
        chk(16'(skew), 16'h0007);
        reset_pin = 1'b1;
        host.step(5);
        reset_pin = 1'b0;
        host.step(25);
        chk(16'(skew), 16'h0000);
        tally_and_finish();
    end
endmodule // acp_config_port_test
